/* src/rwc_top.sv */
// Reset sequencer, qualified undervoltage reset and watchdog control with AXI4-Lite registers
`timescale 1ns/1ps
`include "rwc_map.svh"
module rwc_top (
    // Clock and reset
    input  wire logic              I_MCLK,
    input  wire logic              I_RST,
    // Core and analog
    input  wire logic              I_WATCHDOG_CLEAR_INSTRUCTION,
    input  wire logic              I_HALT,
    input  wire logic              I_LOW_POWER,
    input  wire logic              I_UNDERVOLT,
    output logic                   O_SYS_RST,
    output logic                   O_POR_INIT,
    output logic                   O_PC_SP_CLR,
    output logic                   O_TIMEOUT_FLAG,
    output logic                   O_POWER_DOWN_FLAG,
    output logic                   O_BANDGAP_EN,
    output logic                   O_IRQ,
    // AXI4-Lite write
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output rwc_pkg::rwc_byte_t     S_AXI_RDATA_LO,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);
    import rwc_pkg::*;
    rwc_wdt_if wdt ();

    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    logic [7:0]  wdt_ctrl_reg;
    logic        flag_uv_reg;
    logic        flag_key_reg;
    logic        bandgap_reg;
    logic        to_reg;
    logic        pd_reg;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_mask_reg;
    logic [10:0] tick_cnt_reg;
    logic        tick_reg;
    logic [7:0]  key_cnt_reg;
    logic        key_pend_reg;
    logic [11:0] uv_cnt_reg;
    logic        uv_done_reg;
    logic        uv_meta_reg;
    logic        uv_sync_reg;
    logic [4:0]  rst_cnt_reg;
    logic        sys_rst_reg;
    logic        por_reg;
    logic        pcsp_reg;
    logic        irq_reg;
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [7:0]  awaddr_reg;
    logic [7:0]  wdata_reg;
    logic        wstrb0_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [7:0]  rdata_reg;

    // Bus decode
    wire       do_write  = aw_full_reg && w_full_reg && !bvalid_reg;
    wire       wr_ok     = do_write && wstrb0_reg;
    wire       wr_ctrl   = wr_ok && awaddr_reg == `RWC_OFF_WDT_CTRL;
    wire       wr_flags  = wr_ok && awaddr_reg == `RWC_OFF_RST_FLAGS;
    wire       wr_bg     = wr_ok && awaddr_reg == `RWC_OFF_BANDGAP;
    wire       wr_mask   = wr_ok && awaddr_reg == `RWC_OFF_IRQ_MASK;
    wire       wr_hit    = awaddr_reg == `RWC_OFF_WDT_CTRL || awaddr_reg == `RWC_OFF_RST_FLAGS ||
                           awaddr_reg == `RWC_OFF_BANDGAP || awaddr_reg == `RWC_OFF_IRQ_MASK ||
                           awaddr_reg == `RWC_OFF_CORE_STATUS || awaddr_reg == `RWC_OFF_IRQ_STATUS;
    wire       rd_take   = S_AXI_ARVALID && arready_reg;
    wire       rd_irq    = rd_take && S_AXI_ARADDR == `RWC_OFF_IRQ_STATUS;
    wire       rd_hit    = S_AXI_ARADDR == `RWC_OFF_WDT_CTRL || S_AXI_ARADDR == `RWC_OFF_RST_FLAGS ||
                           S_AXI_ARADDR == `RWC_OFF_BANDGAP || S_AXI_ARADDR == `RWC_OFF_CORE_STATUS ||
                           S_AXI_ARADDR == `RWC_OFF_IRQ_STATUS || S_AXI_ARADDR == `RWC_OFF_IRQ_MASK;
    wire [7:0] rd_mux    = (S_AXI_ARADDR == `RWC_OFF_WDT_CTRL)    ? wdt_ctrl_reg :
                           (S_AXI_ARADDR == `RWC_OFF_RST_FLAGS)   ? {5'h00, flag_uv_reg, 1'b0, flag_key_reg} :
                           (S_AXI_ARADDR == `RWC_OFF_BANDGAP)     ? {7'h00, bandgap_reg} :
                           (S_AXI_ARADDR == `RWC_OFF_CORE_STATUS) ? {6'h00, pd_reg, to_reg} :
                           (S_AXI_ARADDR == `RWC_OFF_IRQ_STATUS)  ? {5'h00, irq_stat_reg} :
                           (S_AXI_ARADDR == `RWC_OFF_IRQ_MASK)    ? {5'h00, irq_mask_reg} : 8'h00;

    wire [4:0] new_key   = wdata_reg[`RWC_KEY_MSB:`RWC_KEY_LSB];
    wire       key_bad   = wr_ctrl && new_key != `RWC_KEY_CODE_A && new_key != `RWC_KEY_CODE_B;
    wire [4:0] cur_key   = wdt_ctrl_reg[`RWC_KEY_MSB:`RWC_KEY_LSB];
    wire       key_ok    = cur_key == `RWC_KEY_CODE_A || cur_key == `RWC_KEY_CODE_B;
    wire       wdt_to    = wdt.timeout;
    wire       to_run    = wdt_to && !I_LOW_POWER;
    wire       to_sleep  = wdt_to && I_LOW_POWER;
    wire       key_fire  = key_pend_reg && key_cnt_reg == 8'h00;
    // qualifier held off in low power
    wire       uv_fire   = uv_sync_reg && !I_LOW_POWER && !uv_done_reg &&
                           uv_cnt_reg == 12'(`RWC_UV_QUALIFY_CYC - 1);
    wire       full_rst  = to_run || key_fire || uv_fire;
    wire [2:0] events    = {uv_fire, key_fire, wdt_to};

    assign wdt.clear     = I_WATCHDOG_CLEAR_INSTRUCTION || I_HALT || key_bad || sys_rst_reg;
    assign wdt.enable    = key_ok;
    assign wdt.tick      = tick_reg;
    assign wdt.ratio_sel = wdt_ctrl_reg[`RWC_SEL_MSB:0];

    rwc_wdt_cnt u_cnt (
        .I_MCLK (I_MCLK),
        .I_RST  (I_RST),
        .wdt    (wdt)
    );

    // Slow oscillator stand-in: one-cycle tick from a divider
    always_ff @(posedge I_MCLK) begin
        if (I_RST || tick_reg) begin
            tick_cnt_reg <= 11'h000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 11'h001;
        end
        tick_reg <= !I_RST && !tick_reg && tick_cnt_reg == 11'(`RWC_SLOW_TICK_CYC - 2);
    end

    // Supply monitor pin is asynchronous
    always_ff @(posedge I_MCLK) begin
        uv_meta_reg <= I_UNDERVOLT;
        uv_sync_reg <= uv_meta_reg;
    end

    // dip must last the qualify time
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !uv_sync_reg || I_LOW_POWER) begin
            uv_cnt_reg  <= 12'h000;
            uv_done_reg <= 1'b0;
        end else if (uv_fire) begin
            uv_done_reg <= 1'b1;
        end else if (!uv_done_reg) begin
            uv_cnt_reg <= uv_cnt_reg + 12'h001;
        end
    end

    // key reset waits out its delay
    always_ff @(posedge I_MCLK) begin
        if (I_RST || full_rst) begin
            key_pend_reg <= 1'b0;
            key_cnt_reg  <= 8'h00;
        end else if (key_bad) begin
            key_pend_reg <= 1'b1;
            key_cnt_reg  <= 8'(`RWC_KEY_DELAY_CYC - 1);
        end else if (key_fire) begin
            key_pend_reg <= 1'b0;
        end else if (key_pend_reg) begin
            key_cnt_reg <= key_cnt_reg - 8'h01;
        end
    end

    // power-on init held through the pulse
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            rst_cnt_reg <= 5'(`RWC_RST_PULSE_CYC);
            sys_rst_reg <= 1'b1;
            por_reg     <= 1'b1;
        end else if (full_rst) begin
            rst_cnt_reg <= 5'(`RWC_RST_PULSE_CYC);
            sys_rst_reg <= 1'b1;
        end else if (rst_cnt_reg != 5'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 5'h01;
        end else begin
            sys_rst_reg <= 1'b0;
            por_reg     <= 1'b0;
        end
    end

    // only PC and SP cleared in low power
    always_ff @(posedge I_MCLK) begin
        pcsp_reg <= !I_RST && to_sleep;
    end

    // watchdog control and bandgap registers reload on full reset
    always_ff @(posedge I_MCLK) begin
        if (I_RST || full_rst) begin
            wdt_ctrl_reg <= `RWC_WDT_CTRL_RESET;
            bandgap_reg  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                wdt_ctrl_reg <= wdata_reg;
            end
            if (wr_bg) begin
                bandgap_reg <= wdata_reg[`RWC_BANDGAP_BIT];
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            flag_uv_reg  <= 1'b0;
            flag_key_reg <= 1'b0;
        end else begin
            flag_uv_reg  <= uv_fire || (flag_uv_reg && !(wr_flags && !wdata_reg[`RWC_FLAG_UV_BIT]));
            flag_key_reg <= key_fire || (flag_key_reg && !(wr_flags && !wdata_reg[`RWC_FLAG_KEY_BIT]));
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            to_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else if (wdt_to) begin
            to_reg <= 1'b1;
            pd_reg <= pd_reg || I_LOW_POWER;
        end else if (I_HALT) begin
            to_reg <= 1'b0;
            pd_reg <= 1'b1;
        end else if (I_WATCHDOG_CLEAR_INSTRUCTION) begin
            pd_reg <= 1'b0;
        end
    end

    // Sticky events, read clears, set wins
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= events | (rd_irq ? 3'h0 : irq_stat_reg);
            irq_reg      <= |((events | (rd_irq ? 3'h0 : irq_stat_reg)) & irq_mask_reg);
            if (wr_mask) begin
                irq_mask_reg <= wdata_reg[2:0];
            end
        end
    end

    // Write channel: address and data in either order
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 8'h00;
            wstrb0_reg  <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && awready_reg) begin
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
                awaddr_reg  <= {S_AXI_AWADDR[7:2], 2'h0};
            end
            if (S_AXI_WVALID && wready_reg) begin
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg  <= S_AXI_WDATA[7:0];
                wstrb0_reg <= S_AXI_WSTRB[0];
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? 2'h0 : 2'h2;
            end
            if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // Read channel, one outstanding
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= 2'h0;
            rdata_reg   <= 8'h00;
        end else if (rd_take) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_mux;
            rresp_reg   <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign O_SYS_RST         = sys_rst_reg;
    assign O_POR_INIT        = por_reg;
    assign O_PC_SP_CLR       = pcsp_reg;
    assign O_TIMEOUT_FLAG    = to_reg;
    assign O_POWER_DOWN_FLAG = pd_reg;
    assign O_BANDGAP_EN      = bandgap_reg;
    assign O_IRQ             = irq_reg;
    assign S_AXI_AWREADY     = awready_reg;
    assign S_AXI_WREADY      = wready_reg;
    assign S_AXI_BVALID      = bvalid_reg;
    assign S_AXI_BRESP       = bresp_reg;
    assign S_AXI_ARREADY     = arready_reg;
    assign S_AXI_RVALID      = rvalid_reg;
    assign S_AXI_RRESP       = rresp_reg;
    assign S_AXI_RDATA_LO    = rdata_reg;

    property p_key_reset;
        key_bad |-> ##(`RWC_KEY_DELAY_CYC) (key_fire || sys_rst_reg);
    endproperty
    a_key_reset: assert property (p_key_reset) else $error("bad key did not reset in time");
    property p_run_to;
        to_run |=> sys_rst_reg && to_reg;
    endproperty
    a_run_to: assert property (p_run_to) else $error("run timeout missed reset");
    property p_sleep_to;
        to_sleep |=> pcsp_reg && to_reg && pd_reg;
    endproperty
    a_sleep_to: assert property (p_sleep_to) else $error("sleep timeout wrong effect");
    property p_clr;
        I_WATCHDOG_CLEAR_INSTRUCTION && !I_HALT && !wdt_to |=> wdt.count == 16'h0000 && !pd_reg;
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not clear");
    property p_halt;
        I_HALT && !wdt_to |=> wdt.count == 16'h0000 && pd_reg && !to_reg;
    endproperty
    a_halt: assert property (p_halt) else $error("halt effect wrong");
    property p_uv_qual;
        uv_fire |-> $past(uv_sync_reg, 8) && !I_LOW_POWER;
    endproperty
    a_uv_qual: assert property (p_uv_qual) else $error("undervoltage not qualified");
    property p_uv_flag;
        uv_fire |=> flag_uv_reg && sys_rst_reg;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("undervoltage flag not set");
    property p_bg;
        sys_rst_reg && $past(full_rst) |-> !bandgap_reg && wdt_ctrl_reg == `RWC_WDT_CTRL_RESET;
    endproperty
    a_bg: assert property (p_bg) else $error("reset reload wrong");
    property p_keyflag;
        key_fire |=> flag_key_reg;
    endproperty
    a_keyflag: assert property (p_keyflag) else $error("key flag not set");
    c_key: cover property (key_fire);
    c_uv: cover property (uv_fire);
    c_sleep: cover property (to_sleep);
endmodule

/* src/rwc_map.svh */
// Register offsets, field positions, reset values and timing counts of the reset controller
`ifndef RWC_MAP_SVH
`define RWC_MAP_SVH
`define RWC_OFF_WDT_CTRL     8'h00
`define RWC_OFF_RST_FLAGS    8'h04
`define RWC_OFF_BANDGAP      8'h08
`define RWC_OFF_CORE_STATUS  8'h0C
`define RWC_OFF_IRQ_STATUS   8'h10
`define RWC_OFF_IRQ_MASK     8'h14
`define RWC_WDT_CTRL_RESET   8'h53
`define RWC_KEY_MSB          7
`define RWC_KEY_LSB          3
`define RWC_KEY_CODE_A       5'h0A
`define RWC_KEY_CODE_B       5'h15
`define RWC_SEL_MSB          2
`define RWC_FLAG_UV_BIT      2
`define RWC_FLAG_KEY_BIT     0
`define RWC_BANDGAP_BIT      0
`define RWC_STAT_TO_BIT      0
`define RWC_STAT_PD_BIT      1
`define RWC_EV_TIMEOUT       0
`define RWC_EV_KEYERR        1
`define RWC_EV_UNDERVOLT     2
`define RWC_CLK_HZ           50000000
`define RWC_SLOW_OSC_HZ      32000
`define RWC_SLOW_TICK_CYC    (`RWC_CLK_HZ / `RWC_SLOW_OSC_HZ)
`define RWC_KEY_DELAY_NS     1000
`define RWC_KEY_DELAY_CYC    ((`RWC_KEY_DELAY_NS * 50 + 999) / 1000)
`define RWC_UV_QUALIFY_NS    60000
`define RWC_UV_QUALIFY_CYC   ((`RWC_UV_QUALIFY_NS * 50 + 999) / 1000)
`define RWC_RST_PULSE_CYC    16
`define RWC_WDT_MIN_EXP      8
`endif

/* src/rwc_pkg.sv */
// Types shared by the reset and watchdog controller
package rwc_pkg;
    typedef enum logic [1:0] {
        RWC_SRC_POWER_ON = 2'h0,
        RWC_SRC_UNDERVOLT = 2'h1,
        RWC_SRC_WATCHDOG = 2'h3,
        RWC_SRC_KEY = 2'h2
    } rwc_src_e;
    typedef logic [7:0] rwc_byte_t;
endpackage

/* src/rwc_wdt_if.sv */
// Signals between the controller and its watchdog counter
`timescale 1ns/1ps
interface rwc_wdt_if;
    logic        clear;
    logic        enable;
    logic        tick;
    logic [2:0]  ratio_sel;
    logic        timeout;
    logic [15:0] count;
    modport ctrl (output clear, output enable, output tick, output ratio_sel, input timeout, input count);
    modport cnt  (input clear, input enable, input tick, input ratio_sel, output timeout, output count);
endinterface

/* src/rwc_wdt_cnt.sv */
// Watchdog counter clocked by slow oscillator ticks
`timescale 1ns/1ps
`include "rwc_map.svh"
module rwc_wdt_cnt (
    input  wire logic I_MCLK,
    input  wire logic I_RST,
    rwc_wdt_if.cnt    wdt
);
    import rwc_pkg::*;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        timeout_reg;
    wire  [15:0] limit;
    wire         at_limit;

    assign limit      = (16'h0100 << wdt.ratio_sel) - 16'h0001;
    assign at_limit   = (count_reg == limit);
    assign count_next = (wdt.clear || (wdt.tick && at_limit)) ? 16'h0000 :
                        (wdt.tick ? count_reg + 16'h0001 : count_reg);
    assign wdt.count  = count_reg;
    assign wdt.timeout = timeout_reg;

    always_ff @(posedge I_MCLK) begin
        if (I_RST || !wdt.enable) begin
            count_reg   <= 16'h0000;
            timeout_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            timeout_reg <= wdt.tick && at_limit && !wdt.clear;
        end
    end

    property p_period;
        @(posedge I_MCLK) disable iff (I_RST)
        timeout_reg |-> $past(count_reg) == (16'h0100 << $past(wdt.ratio_sel)) - 16'h0001;
    endproperty
    a_period: assert property (p_period) else $error("watchdog expired at wrong count");
    property p_clear;
        @(posedge I_MCLK) disable iff (I_RST)
        wdt.clear |=> count_reg == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");
    c_long: cover property (@(posedge I_MCLK) timeout_reg && wdt.ratio_sel == 3'h7);
endmodule

/* bench/rwc_core_model.sv */
// Core model issuing watchdog clear and halt pulses and the low-power level
`timescale 1ns/1ps
module rwc_core_model (
    // Clock
    input  wire logic i_clk,
    // Instruction events
    output logic      o_watchdog_clear_instruction,
    output logic      o_halt,
    output logic      o_low_power
);
    initial begin
        o_watchdog_clear_instruction = 1'b0;
        o_halt = 1'b0;
        o_low_power = 1'b0;
    end
    task automatic clear_wdt();
        @(posedge i_clk);
        o_watchdog_clear_instruction <= 1'b1;
        @(posedge i_clk);
        o_watchdog_clear_instruction <= 1'b0;
    endtask
    // Halt, optionally staying asleep until wake
    task automatic halt(input logic sleep);
        @(posedge i_clk);
        o_halt <= 1'b1;
        @(posedge i_clk);
        o_halt <= 1'b0;
        o_low_power <= sleep;
    endtask
    task automatic wake();
        @(posedge i_clk);
        o_low_power <= 1'b0;
    endtask
endmodule

/* bench/test_reset_and_watchdog_control.sv */
// Self-checking bench for the reset and watchdog controller
`timescale 1ns/1ps
module test_reset_and_watchdog_control;
    import rwc_pkg::*;
    logic       mclk, rst, uv, clr, hlt, lowp, sys_rst, por, pcsp, to_f, pd_f, bg, irq;
    logic       awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    rwc_byte_t  rdata;
    int         fails, num_checks;

    rwc_top rwc_top_i (.I_MCLK(mclk), .I_RST(rst), .I_WATCHDOG_CLEAR_INSTRUCTION(clr), .I_HALT(hlt), .I_LOW_POWER(lowp),
        .I_UNDERVOLT(uv), .O_SYS_RST(sys_rst), .O_POR_INIT(por), .O_PC_SP_CLR(pcsp), .O_TIMEOUT_FLAG(to_f),
        .O_POWER_DOWN_FLAG(pd_f), .O_BANDGAP_EN(bg), .O_IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA_LO(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    rwc_core_model rwc_core_model_i (.i_clk(mclk), .o_watchdog_clear_instruction(clr), .o_halt(hlt), .o_low_power(lowp));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Both channels offered together; each released once taken
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) break;
        end
        check("bvalid", 8'h01, {7'h0, bv});
        check("bresp", 8'h00, {6'h0, bresp});
    endtask

    // Data compared only when an OKAY answer is expected
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        araddr <= a;
        arv <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        check("rvalid", 8'h01, {7'h0, rv});
        check("rresp", {6'h0, er}, {6'h0, rresp});
        if (er == 2'b00) check($sformatf("reg %h", a), exp, rdata);
    endtask

    // Watches a window for a full reset, then lets it finish
    task automatic expect_rst(input int cyc, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (cyc) begin
            @(posedge mclk);
            seen = seen | sys_rst;
        end
        repeat (100) begin
            if (!sys_rst) break;
            @(posedge mclk);
        end
        check("full reset seen", {7'h0, exp}, {7'h0, seen});
    endtask

    task automatic t_regs();
        rd_reg(8'h00, 8'h53, 2'b00);
        rd_reg(8'h08, 8'h00, 2'b00);
        rd_reg(8'h04, 8'h00, 2'b00);
        wr_reg(8'h08, 8'hFF);
        rd_reg(8'h08, 8'h01, 2'b00);
        check("bandgap out", 8'h01, {7'h0, bg});
        // Write without byte lane 0 must not land
        wstrb <= 4'h0;
        wr_reg(8'h08, 8'h00);
        wstrb <= 4'h1;
        rd_reg(8'h08, 8'h01, 2'b00);
        rd_reg(8'h1C, 8'h00, 2'b10);
    endtask

    task automatic t_halt();
        rwc_core_model_i.halt(1'b0);
        @(posedge mclk);
        check("pdf after halt", 8'h01, {7'h0, pd_f});
        rd_reg(8'h0C, 8'h02, 2'b00);
        rwc_core_model_i.clear_wdt();
        @(posedge mclk);
        check("pdf after clear", 8'h00, {7'h0, pd_f});
    endtask

    task automatic t_key();
        wr_reg(8'h00, 8'hAB);
        expect_rst(100, 1'b0);
        rd_reg(8'h00, 8'hAB, 2'b00);
        wr_reg(8'h00, 8'hF8);
        expect_rst(200, 1'b1);
        check("por after key reset", 8'h00, {7'h0, por});
        rd_reg(8'h00, 8'h53, 2'b00);
        rd_reg(8'h04, 8'h01, 2'b00);
        wr_reg(8'h04, 8'hFF);
        rd_reg(8'h04, 8'h01, 2'b00);
        wr_reg(8'h04, 8'h00);
        rd_reg(8'h04, 8'h00, 2'b00);
    endtask

    task automatic t_undervolt();
        rwc_core_model_i.halt(1'b1);
        uv <= 1'b1;
        expect_rst(4000, 1'b0);
        uv <= 1'b0;
        repeat (5) @(posedge mclk);
        rwc_core_model_i.wake();
        uv <= 1'b1;
        expect_rst(1000, 1'b0);
        uv <= 1'b0;
        repeat (5) @(posedge mclk);
        uv <= 1'b1;
        expect_rst(3200, 1'b1);
        uv <= 1'b0;
        check("pdf kept", 8'h01, {7'h0, pd_f});
        check("timeout kept", 8'h00, {7'h0, to_f});
        check("pc sp clear idle", 8'h00, {7'h0, pcsp});
        rd_reg(8'h04, 8'h04, 2'b00);
        check("irq masked", 8'h00, {7'h0, irq});
        wr_reg(8'h14, 8'h04);
        repeat (3) @(posedge mclk);
        check("irq unmasked", 8'h01, {7'h0, irq});
        rd_reg(8'h10, 8'h06, 2'b00);
        repeat (3) @(posedge mclk);
        check("irq after read", 8'h00, {7'h0, irq});
        wr_reg(8'h04, 8'h00);
        rd_reg(8'h04, 8'h00, 2'b00);
    endtask

    // Hang guard, far beyond the expected run of about 8600 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        report_and_stop();
    end

    initial begin
        fails = 0;
        num_checks = 0;
        rst = 1'b1;
        uv = 1'b0;
        // Response readies held high for the whole run
        {awv, wv, br, arv, rr} = 5'h05;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h1;
        repeat (6) @(posedge mclk);
        check("por init", 8'h01, {7'h0, por});
        check("sys reset", 8'h01, {7'h0, sys_rst});
        check("flags at power on", 8'h00, {6'h0, pd_f, to_f});
        rst <= 1'b0;
        expect_rst(1, 1'b1);
        check("por init done", 8'h00, {7'h0, por});
        t_regs();
        t_halt();
        t_key();
        t_undervolt();
        report_and_stop();
    end
endmodule
